/* rpl_reset_pin.sv */
// external reset pin logic: holds the chip in reset from the pin, drives the
// pin low as an open-drain indicator for internal resets, records the cause
// and sets the reset-default port configuration. APB register slave.
// assumes internal event inputs are one-cycle pulses on pclk and that the
// board pulls the pin high through a resistor.
//
// Summary of operation
// - ports A-C reset to inputs, alternates off
// - port D0 takes reset function at power-up
// - four-cycle low pulse always resets; three may
// - stay in reset while pin held low
// - long hold: leave reset right after release
// - external reset sets external cause flag
// - pin indicates reset as open-drain output
// - indicate internal resets too: power, brownout, watchdog
// - internal event starts pin drive immediately
// - drive pin until source delay has elapsed
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module rpl_reset_pin #(
  parameter int unsigned EXT_TIMEOUT = rpl_pkg::EXT_TIMEOUT_CYC,
  parameter int unsigned POR_DELAY = rpl_pkg::POR_DELAY_CYC,
  parameter int unsigned BROWNOUT_DELAY = rpl_pkg::BROWNOUT_DELAY_CYC,
  parameter int unsigned WATCHDOG_DELAY = rpl_pkg::WATCHDOG_DELAY_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reset pin, open drain
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  // internal reset sources
  input wire logic power_on_reset,
  input wire logic supply_brownout_reset,
  input wire logic watchdog_timeout_reset,
  // chip side
  output logic sys_reset_n,
  output logic [23:0] port_dir,
  output logic [23:0] port_alt,
  output logic port_d0_reset_alt,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // parameter checks: every delay must fit the counter and be at least one
  localparam int unsigned CNT_MAX = (1 << rpl_pkg::CNT_W) - 1;
  if (EXT_TIMEOUT < 1 || EXT_TIMEOUT > CNT_MAX)
  begin : g_bad_ext
    $error("EXT_TIMEOUT out of range");
  end
  if (POR_DELAY < 1 || POR_DELAY > CNT_MAX)
  begin : g_bad_por
    $error("POR_DELAY out of range");
  end
  if (BROWNOUT_DELAY < 1 || BROWNOUT_DELAY > CNT_MAX)
  begin : g_bad_bo
    $error("BROWNOUT_DELAY out of range");
  end
  if (WATCHDOG_DELAY < 1 || WATCHDOG_DELAY > CNT_MAX)
  begin : g_bad_wd
    $error("WATCHDOG_DELAY out of range");
  end

  localparam logic [rpl_pkg::CNT_W-1:0] EXT_CNT = rpl_pkg::CNT_W'(EXT_TIMEOUT - 1);
  localparam logic [rpl_pkg::CNT_W-1:0] POR_CNT = rpl_pkg::CNT_W'(POR_DELAY - 1);
  localparam logic [rpl_pkg::CNT_W-1:0] BO_CNT = rpl_pkg::CNT_W'(BROWNOUT_DELAY - 1);
  localparam logic [rpl_pkg::CNT_W-1:0] WD_CNT = rpl_pkg::CNT_W'(WATCHDOG_DELAY - 1);

  rpl_pkg::rpl_main_s s_reg;
  rpl_pkg::rpl_main_s s_next;

  logic pin_level;
  logic low_accept;
  logic int_event;
  logic setup_ph;
  logic access_ph;
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  logic [31:0] rd_val;

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling; blind while we drive and shortly after, so our own low
  // level coming back through the synchroniser is never taken as external
  rpl_pin_filter u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(rst_pin_in),
    .ignore(s_reg.drive || s_reg.blank != 2'h0),
    .pin_level(pin_level),
    .low_accept(low_accept)
  );

  // bus phases
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign wr_acc = access_ph && pwrite;
  assign rd_acc = access_ph && !pwrite;
  assign int_event = power_on_reset || supply_brownout_reset || watchdog_timeout_reset;

  // address decode and read value, sampled in the setup phase
  always_comb
  begin
    mapped = 1'b1;
    rd_val = 32'h00000000;
    case (paddr)
      rpl_pkg::CTRL_OFS:
      begin
        rd_val[rpl_pkg::CTRL_FORCE_BIT] = s_reg.force_ind;
        rd_val[rpl_pkg::CTRL_D0_ALT_BIT] = s_reg.d0_alt;
      end
      rpl_pkg::CAUSE_OFS: rd_val[3:0] = s_reg.cause;
      rpl_pkg::STATE_OFS:
      begin
        rd_val[rpl_pkg::STATE_IN_RESET_BIT] = (s_reg.st != rpl_pkg::ST_RUN);
        rd_val[rpl_pkg::STATE_PIN_LEVEL_BIT] = pin_level;
        rd_val[rpl_pkg::STATE_PIN_DRIVEN_BIT] = s_reg.drive;
      end
      rpl_pkg::PORT_DIR_OFS: rd_val[23:0] = s_reg.dir;
      rpl_pkg::PORT_ALT_OFS: rd_val[23:0] = s_reg.alt;
      rpl_pkg::INT_STATUS_OFS: rd_val[1:0] = s_reg.int_st;
      rpl_pkg::INT_MASK_OFS: rd_val[1:0] = s_reg.int_mask;
      default: mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    s_next = s_reg;

    // read data and error are prepared in setup, held through access
    if (setup_ph)
    begin
      s_next.prdata = pwrite ? 32'h00000000 : rd_val;
      s_next.pslverr = !mapped;
    end

    // register writes take effect at the access edge
    if (wr_acc)
    begin
      case (paddr)
        rpl_pkg::CTRL_OFS:
        begin
          s_next.force_ind = pwdata[rpl_pkg::CTRL_FORCE_BIT];
          s_next.d0_alt = pwdata[rpl_pkg::CTRL_D0_ALT_BIT];
        end
        rpl_pkg::CAUSE_OFS: s_next.cause = s_reg.cause & ~pwdata[3:0]; // write 1 clears
        rpl_pkg::PORT_DIR_OFS: s_next.dir = pwdata[23:0];
        rpl_pkg::PORT_ALT_OFS: s_next.alt = pwdata[23:0];
        rpl_pkg::INT_MASK_OFS: s_next.int_mask = pwdata[1:0];
        default: s_next.int_mask = s_reg.int_mask;
      endcase
    end

    // reading the interrupt status clears it; events below still win
    if (rd_acc && paddr == rpl_pkg::INT_STATUS_OFS)
      s_next.int_st = 2'h0;

    if (s_reg.blank != 2'h0)
      s_next.blank = s_reg.blank - 2'h1;

    // sequencer
    case (s_reg.st)
      rpl_pkg::ST_RUN:
      begin
        if (low_accept)
        begin
          s_next.st = rpl_pkg::ST_EXT;
          s_next.cnt = EXT_CNT;
        end
      end
      rpl_pkg::ST_EXT:
      begin
        if (s_reg.cnt != '0)
          s_next.cnt = s_reg.cnt - 1'b1;
        // stay while the pin is low; leave on the first edge that sees it high
        else if (pin_level)
        begin
          s_next.st = rpl_pkg::ST_RUN;
          s_next.cause[rpl_pkg::CAUSE_EXT_BIT] = 1'b1;
          s_next.int_st[rpl_pkg::INT_EXT_DONE_BIT] = 1'b1;
        end
      end
      rpl_pkg::ST_INT:
      begin
        // pin held low until the source delay has run out
        if (s_reg.cnt != '0)
          s_next.cnt = s_reg.cnt - 1'b1;
        else
        begin
          s_next.st = rpl_pkg::ST_RUN;
          s_next.blank = rpl_pkg::PIN_BLANK_CYC;
          s_next.int_st[rpl_pkg::INT_INT_DONE_BIT] = 1'b1;
        end
      end
      default:
      begin
        s_next.st = rpl_pkg::ST_RUN;
        s_next.cnt = '0;
      end
    endcase

    // an internal event overrides everything and restarts its own delay
    if (int_event)
    begin
      s_next.st = rpl_pkg::ST_INT;
      if (power_on_reset)
        s_next.cnt = POR_CNT;
      else if (supply_brownout_reset)
        s_next.cnt = BO_CNT;
      else
        s_next.cnt = WD_CNT;
      s_next.cause[rpl_pkg::CAUSE_POR_BIT] = s_next.cause[rpl_pkg::CAUSE_POR_BIT] || power_on_reset;
      s_next.cause[rpl_pkg::CAUSE_BROWNOUT_BIT] =
        s_next.cause[rpl_pkg::CAUSE_BROWNOUT_BIT] || supply_brownout_reset;
      s_next.cause[rpl_pkg::CAUSE_WATCHDOG_BIT] =
        s_next.cause[rpl_pkg::CAUSE_WATCHDOG_BIT] || watchdog_timeout_reset;
      // power-up gives port D0 back to the reset function
      if (power_on_reset)
        s_next.d0_alt = 1'b1;
    end

    // while in any reset, port configuration returns to its defaults
    if (s_next.st != rpl_pkg::ST_RUN)
    begin
      s_next.dir = rpl_pkg::PORT_DIR_RST;
      s_next.alt = rpl_pkg::PORT_ALT_RST;
    end

    // open-drain drive: internal resets from the event edge, or software force.
    // external resets are not driven back, or the pin would latch itself low
    s_next.drive = (s_next.st == rpl_pkg::ST_INT) || s_next.force_ind;
    // any release of the pin, forced or not, blinds the filter while our own
    // low level drains out of the synchroniser
    if (s_reg.drive && !s_next.drive)
      s_next.blank = rpl_pkg::PIN_BLANK_CYC;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg <= '0;
      s_reg.st <= rpl_pkg::ST_RUN;
      s_reg.d0_alt <= 1'b1;
      s_reg.cause <= rpl_pkg::CAUSE_RST;
      s_reg.dir <= rpl_pkg::PORT_DIR_RST;
      s_reg.alt <= rpl_pkg::PORT_ALT_RST;
      s_reg.int_st <= rpl_pkg::INT_RST;
      s_reg.int_mask <= rpl_pkg::INT_RST;
    end
    else
      s_reg <= s_next;
  end

  // outputs
  assign prdata = s_reg.prdata;
  assign pslverr = s_reg.pslverr && access_ph;
  assign pready = 1'b1; // answers in the first access cycle
  assign rst_pin_out = 1'b0; // open drain: only ever pulls low
  assign rst_pin_oe = s_reg.drive;
  assign sys_reset_n = (s_reg.st == rpl_pkg::ST_RUN);
  assign port_dir = s_reg.dir;
  assign port_alt = s_reg.alt;
  assign port_d0_reset_alt = s_reg.d0_alt;
  assign irq = |(s_reg.int_st & s_reg.int_mask);

  ////////////////////////////////////////////////////////////////////////////
  // checks; they watch the registered state, so each |=> consequent describes
  // the edge after the one that took the antecedent
  a_port_default: assert property (@(posedge pclk) disable iff (!presetn)
    !sys_reset_n |-> port_dir == rpl_pkg::PORT_DIR_RST && port_alt == rpl_pkg::PORT_ALT_RST)
    else $error("ports not at default during reset");

  a_d0_power_up: assert property (@(posedge pclk) disable iff (!presetn)
    power_on_reset |=> port_d0_reset_alt)
    else $error("port D0 not on reset function after power-up");

  a_accept_enters: assert property (@(posedge pclk) disable iff (!presetn)
    sys_reset_n && low_accept && !int_event |=> !sys_reset_n)
    else $error("accepted pulse did not start reset");

  a_hold_low_pin: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.st == rpl_pkg::ST_EXT && !pin_level && !int_event |=> !sys_reset_n)
    else $error("left reset while pin low");

  a_leave_release: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.st == rpl_pkg::ST_EXT && s_reg.cnt == '0 && pin_level && !int_event
      |=> sys_reset_n ##0 s_reg.cause[rpl_pkg::CAUSE_EXT_BIT])
    else $error("no exit or cause flag after pin release");

  a_drive_now: assert property (@(posedge pclk) disable iff (!presetn)
    int_event |=> rst_pin_oe && !rst_pin_out)
    else $error("pin not driven after internal event");

  a_drive_hold: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.st == rpl_pkg::ST_INT |-> rst_pin_oe && !sys_reset_n)
    else $error("internal reset not indicated on pin");

  a_drive_length: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(rst_pin_oe) && !s_reg.force_ind && s_reg.cnt == POR_CNT
      && $past(power_on_reset) && POR_DELAY <= 8
      |-> rst_pin_oe [*1] ##(POR_DELAY) !rst_pin_oe || $past(int_event))
    else $error("power-on drive length wrong");

  a_cnt_steps: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.st == rpl_pkg::ST_INT && s_reg.cnt != '0 && !int_event
      |=> s_reg.st == rpl_pkg::ST_INT && s_reg.cnt == $past(s_reg.cnt) - 1'b1)
    else $error("delay counter did not count down");

  // the pin is let go as soon as the delay has run out, unless software forces it
  a_int_exit: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.st == rpl_pkg::ST_INT && s_reg.cnt == '0 && !int_event
      && !s_reg.force_ind && !wr_acc |=> sys_reset_n && !rst_pin_oe)
    else $error("pin held past the reset delay");

  // a power-on event always leaves its cause, even against a clearing write
  a_cause_power: assert property (@(posedge pclk) disable iff (!presetn)
    power_on_reset |=> s_reg.cause[rpl_pkg::CAUSE_POR_BIT])
    else $error("power-on cause not recorded");

  // an external reset is not driven back unless software forces the pin, or the pin would hold itself low
  a_ext_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
    s_reg.st == rpl_pkg::ST_EXT && !s_reg.force_ind |-> !rst_pin_oe)
    else $error("external reset driven back onto the pin");

endmodule : rpl_reset_pin

`default_nettype wire

/* rpl_pkg.sv */
// package for the external reset pin logic: register map, field positions,
// reset values, state codes and default cycle counts.
// assumes a single 25 MHz clock and an APB register port.
package rpl_pkg;

  // clock
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned CLK_PERIOD_NS = 1000000000 / CLK_HZ;

  // pin filter: consecutive low samples that accept an external pulse
  localparam int unsigned PIN_LOW_SAMPLES = 3;
  // cycles the filter stays blind after the pin is released by us
  localparam logic [1:0] PIN_BLANK_CYC = 2'h2;

  // default reset delays in cycles, one per source
  localparam int unsigned EXT_TIMEOUT_CYC = 64;
  localparam int unsigned POR_DELAY_CYC = 64;
  localparam int unsigned BROWNOUT_DELAY_CYC = 64;
  localparam int unsigned WATCHDOG_DELAY_CYC = 64;
  localparam int unsigned CNT_W = 16;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CAUSE_OFS = 8'h04;
  localparam logic [7:0] STATE_OFS = 8'h08;
  localparam logic [7:0] PORT_DIR_OFS = 8'h0C;
  localparam logic [7:0] PORT_ALT_OFS = 8'h10;
  localparam logic [7:0] INT_STATUS_OFS = 8'h14;
  localparam logic [7:0] INT_MASK_OFS = 8'h18;

  // control register fields
  localparam int unsigned CTRL_FORCE_BIT = 0;
  localparam int unsigned CTRL_D0_ALT_BIT = 1;

  // reset cause register fields
  localparam int unsigned CAUSE_EXT_BIT = 0;
  localparam int unsigned CAUSE_POR_BIT = 1;
  localparam int unsigned CAUSE_BROWNOUT_BIT = 2;
  localparam int unsigned CAUSE_WATCHDOG_BIT = 3;

  // state register fields
  localparam int unsigned STATE_IN_RESET_BIT = 0;
  localparam int unsigned STATE_PIN_LEVEL_BIT = 1;
  localparam int unsigned STATE_PIN_DRIVEN_BIT = 2;

  // interrupt status fields
  localparam int unsigned INT_EXT_DONE_BIT = 0;
  localparam int unsigned INT_INT_DONE_BIT = 1;

  // port configuration: ports A, B, C, 8 pins each
  localparam int unsigned PORT_PINS = 24;
  localparam logic [23:0] PORT_DIR_RST = 24'hFFFFFF; // all inputs
  localparam logic [23:0] PORT_ALT_RST = 24'h000000; // alternates off
  localparam logic [3:0] CAUSE_RST = 4'h0;
  localparam logic [1:0] INT_RST = 2'h0;

  // sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_EXT = 3'b010,
    ST_INT = 3'b100
  } rpl_state_e;

  // all state of the main module
  typedef struct packed {
    rpl_state_e st;
    logic [CNT_W-1:0] cnt;
    logic [1:0] blank;
    logic drive;
    logic force_ind;
    logic d0_alt;
    logic [3:0] cause;
    logic [23:0] dir;
    logic [23:0] alt;
    logic [1:0] int_st;
    logic [1:0] int_mask;
    logic [31:0] prdata;
    logic pslverr;
  } rpl_main_s;

  // all state of the pin filter
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [1:0] lowcnt;
    logic accept;
  } rpl_filt_s;

endpackage : rpl_pkg

/* rpl_pin_filter.sv */
// pin filter: two-flop synchroniser and low-pulse qualifier for the reset pin.
// assumes the pin input is released by the owner of ignore while it drives.
`timescale 1ns/1ps
`default_nettype none

module rpl_pin_filter (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin side
  input wire logic pin_in,
  input wire logic ignore,
  // qualified results
  output logic pin_level,
  output logic low_accept
);

  rpl_pkg::rpl_filt_s s_reg;
  rpl_pkg::rpl_filt_s s_next;

  ////////////////////////////////////////////////////////////////////////////
  // next state: sync1 feeds sync2 only, everything else looks at sync2
  always_comb
  begin
    s_next = s_reg;
    s_next.sync1 = pin_in;
    s_next.sync2 = s_reg.sync1;
    if (ignore)
    begin
      // our own drive must not look like an external pulse
      s_next.lowcnt = 2'h0;
      s_next.accept = 1'b0;
    end
    else if (!s_reg.sync2)
    begin
      if (s_reg.lowcnt != 2'(rpl_pkg::PIN_LOW_SAMPLES))
        s_next.lowcnt = s_reg.lowcnt + 2'h1;
      // a level, not a pulse: a long hold keeps it up; three cycles may pass
      s_next.accept = (s_reg.lowcnt >= 2'(rpl_pkg::PIN_LOW_SAMPLES - 1));
    end
    else
    begin
      s_next.lowcnt = 2'h0;
      s_next.accept = 1'b0;
    end
  end

  // register the whole state; the pin idles high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_reg <= '{sync1: 1'b1, sync2: 1'b1, lowcnt: 2'h0, accept: 1'b0};
    else
      s_reg <= s_next;
  end

  assign pin_level = s_reg.sync2;
  assign low_accept = s_reg.accept;

  ////////////////////////////////////////////////////////////////////////////
  // a pin held low for four cycles is accepted within a few cycles
  a_four_low_accept: assert property (@(posedge pclk) disable iff (!presetn)
    (!ignore && !pin_in)[*4] ##1 !ignore [*2] |-> ##[0:1] low_accept)
    else $error("four-cycle low pulse not accepted");

endmodule : rpl_pin_filter

`default_nettype wire

/* rpl_board_model.sv */
// board model: pull-up on the reset pin, the device's open-drain driver and
// an external reset source that pulls the pin low on request.
// assumes the device pulls low with rst_pin_oe high and rst_pin_out low.
`timescale 1ns/1ps
`default_nettype none

module rpl_board_model (
  // clock
  input wire logic pclk,
  // device side of the pin
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe,
  // resolved wire level
  output wire logic pin
);
  logic ext_low;

  ////////////////////////////////////////////////////////////
  // wired-and with a pull-up: anyone may pull low, nobody drives high
  assign pin = !((rst_pin_oe && !rst_pin_out) || ext_low);

  initial ext_low = 1'b0;

  // external source holds the pin low for n whole clock cycles
  task automatic hold_low(input int n);
    ext_low <= 1'b1;
    repeat (n) @(posedge pclk);
    ext_low <= 1'b0;
  endtask : hold_low
endmodule : rpl_board_model
`default_nettype wire

/* rpl_reset_pin_tb.sv */
// testbench for the reset pin logic: register defaults, internal events,
// forced drive and external pulses through the board model.
// assumes rpl_pkg, the design and the board model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module rpl_reset_pin_tb;
  // short delays, distinct per source so a swapped delay shows
  localparam int DLY [3] = '{4, 5, 6};
  localparam logic [7:0] OFS [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  localparam logic [31:0] RST [7] = '{32'h2, 32'h0, 32'h2, 32'hFFFFFF, 32'h0, 32'h0, 32'h0};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic rst_pin_in, rst_pin_out, rst_pin_oe, sys_reset_n, port_d0_reset_alt, irq, saw_rst;
  logic [2:0] ev;
  logic [23:0] port_dir, port_alt;
  logic [32:0] exp_q [$];
  int err_total, comparisons, cyc, n;

  rpl_reset_pin #(.EXT_TIMEOUT(4), .POR_DELAY(4), .BROWNOUT_DELAY(5), .WATCHDOG_DELAY(6)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
    .power_on_reset(ev[0]), .supply_brownout_reset(ev[1]), .watchdog_timeout_reset(ev[2]),
    .sys_reset_n(sys_reset_n), .port_dir(port_dir), .port_alt(port_alt),
    .port_d0_reset_alt(port_d0_reset_alt), .irq(irq));

  rpl_board_model brd (.pclk(pclk), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
    .pin(rst_pin_in));

  ////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input logic [32:0] seen, input logic [32:0] exp, input string msg);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // one apb transfer; the note holds {pslverr, read data} (data 0 for writes)
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    exp_q.push_back(exp);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  // monitor: the completing edge of a transfer retires the oldest note
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
      check({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front(), "apb");
    if (sys_reset_n === 1'b0)
      saw_rst <= 1'b1;
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      summarize();
    end
  end

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ev} = '0;
    void'($urandom(32'h1a4d297b));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // reset defaults, then an unmapped address
    for (int i = 0; i < 7; i++)
      apb(1'b0, OFS[i], 32'h0, {1'b0, RST[i]});
    apb(1'b0, 8'h1C, 32'h0, {1'b1, 32'h0});
    check({1'b0, port_dir, port_alt[7:0]}, {1'b0, rpl_pkg::PORT_DIR_RST, 8'h00}, "dir alt");
    check({32'h0, port_d0_reset_alt}, 33'h1, "d0 reset");
    $display("test defaults done");
    // internal sources; irq masked for the brownout pass only
    for (int s = 0; s < 3; s++)
    begin
      r = $urandom;
      apb(1'b1, OFS[4], r, 33'h0);
      apb(1'b1, OFS[3], r & 32'hFFFFFFF0, 33'h0);
      apb(1'b1, OFS[0], 32'h0, 33'h0);
      apb(1'b1, OFS[6], (s == 1) ? 32'h0 : 32'h2, 33'h0);
      @(posedge pclk);
      ev[s] <= 1'b1;
      @(posedge pclk);
      ev[s] <= 1'b0;
      #1;
      check({30'h0, rst_pin_oe, sys_reset_n, rst_pin_in}, 33'h4, "pin drive");
      n = 0;
      while (rst_pin_oe === 1'b1 && n < 100)
      begin
        n++;
        @(posedge pclk);
        #1;
      end
      check(33'(n), 33'(DLY[s]), "drive length");
      check({31'h0, sys_reset_n, irq}, {31'h0, 1'b1, s != 1}, "exit irq");
      apb(1'b0, OFS[5], 32'h0, 33'h2);
      #1;
      check({32'h0, irq}, 33'h0, "irq cleared");
      apb(1'b0, OFS[1], 32'h0, {1'b0, 32'h1 << (s + 1)});
      apb(1'b1, OFS[1], 32'hF, 33'h0);
      apb(1'b0, OFS[4], 32'h0, 33'h0);
      apb(1'b0, OFS[3], 32'h0, {9'h0, rpl_pkg::PORT_DIR_RST});
      apb(1'b0, OFS[0], 32'h0, {31'h0, s == 0, 1'b0});
    end
    $display("test internal done");
    // forced indicator, then a write to the read-only state register
    apb(1'b1, OFS[0], 32'h3, 33'h0);
    repeat (3) @(posedge pclk);
    check({31'h0, rst_pin_oe, rst_pin_in}, 33'h2, "force");
    apb(1'b0, OFS[2], 32'h0, 33'h4);
    apb(1'b1, OFS[0], 32'h2, 33'h0);
    apb(1'b1, OFS[2], 32'hFFFFFFFF, 33'h0);
    repeat (3) @(posedge pclk);
    apb(1'b0, OFS[2], 32'h0, 33'h2);
    $display("test force done");
    // external pulses: too short, random accepted length, long hold
    for (int k = 0; k < 3; k++)
    begin
      saw_rst = 1'b0;
      @(posedge pclk);
      brd.hold_low((k == 0) ? 2 : (k == 1) ? 4 + int'($urandom % 3) : 20);
      #1;
      if (k == 2)
        check({32'h0, sys_reset_n}, 33'h0, "held low");
      n = 0;
      while (sys_reset_n === 1'b0 && n < 100)
      begin
        n++;
        @(posedge pclk);
        #1;
      end
      if (k == 2)
        check(33'(n), 33'd3, "exit delay");
      repeat (12) @(posedge pclk);
      check({32'h0, saw_rst}, {32'h0, k != 0}, "accept");
      apb(1'b0, OFS[1], 32'h0, {32'h0, k != 0});
      apb(1'b1, OFS[1], 32'h1, 33'h0);
      apb(1'b0, OFS[5], 32'h0, {32'h0, k != 0});
    end
    $display("test external done");
    summarize();
  end
endmodule : rpl_reset_pin_tb
`default_nettype wire
